// >>> logic/phw_defines.vh
// Purpose: constants shared by the pcm highway block
// Assumes: system clock of 200 MHz
// Notes: offsets are byte offsets inside the block window
`ifndef PHW_DEFINES_VH
`define PHW_DEFINES_VH
// system clock rate and its value in kHz
`define PHW_CLK_MHZ 200
`define PHW_SYS_KHZ 18'h30D40
// bit clock half periods per ms at the lowest rate
`define PHW_EDGE_KHZ 14'h0200
// slots per frame at the top rate, bits per slot
`define PHW_SLOTS 32
`define PHW_SLOT_BITS 8
// register pages (address bits 9:4)
`define PHW_PG_PFS 6'h1D
`define PHW_PG_TSEN 6'h1E
`define PHW_PG_CTRL 6'h20
// control register fields (bits 1:0 are the bit rate)
`define PHW_C_DCLK 2
`define PHW_C_TXE 3
`define PHW_C_RXE 4
`define PHW_C_WLO 5
`define PHW_C_WHI 7
`define PHW_C_WEN 8
`define PHW_C_MST 9
`define PHW_C_PERM 10
`define PHW_C_BOFF 11
`define PHW_C_BCEN 12
`define PHW_C_FSEN 13
`define PHW_C_UART 14
// status bits in the control word
`define PHW_S_DATA 16
`define PHW_S_BCLK 17
// reset values and masks
`define PHW_CTRL_RST 15'h0000
`define PHW_TSEN_RST 32'h00000000
`define PHW_PFS_RST 16'h0000
`define PHW_UART_MASK 15'h4DFF
`endif

// >>> logic/phw_sync.v
// Purpose: three stage synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
module phw_sync #(
   parameter W = 1
) (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // levels
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;
   reg [W-1:0] q_reg;
   wire [W-1:0] agree = ~(s2_reg ^ s3_reg);

   // shift chain, accept only agreeing bits
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
         q_reg <= {W{1'b0}};
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= (s3_reg & agree) | (q_reg & ~agree);
      end
   end
   assign q_o = q_reg;
endmodule // phw_sync

// >>> logic/phw_port.v
// Purpose: serial engine of one pcm highway
// Assumes: pin inputs arrive synchronised
// Notes: master timing from a fractional tick counter
`timescale 1ns/1ps
`include "phw_defines.vh"
module phw_port (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // configuration and slot data
   input wire [14:0] ctrl_i,
   input wire [31:0] slot_en_i,
   input wire [7:0] tx_byte_i,
   // synchronised pin levels
   input wire bclk_s_i,
   input wire fsc_s_i,
   input wire sdi_s_i,
   // pin drive
   output reg bclk_o,
   output reg bclk_oe_o,
   output reg fsc_o,
   output reg fsc_oe_o,
   output reg sdo_o,
   output reg sdo_oe_o,
   // buffer side
   output wire [4:0] slot_o,
   output wire swap_o,
   output reg rx_wr_o,
   output reg [4:0] rx_slot_o,
   output reg [7:0] rx_byte_o,
   // status
   output reg [8:0] bcyc_o,
   output reg data_run_o,
   output reg bclk_run_o
);
   reg [17:0] acc_reg;
   reg bq_reg, bp_reg, fp_reg, fpend_reg, ph_reg, en_reg;
   reg [7:0] cnt_reg, tsh_reg, rsh_reg;
   reg [2:0] wcnt_reg;
   wire mst = ctrl_i[`PHW_C_MST];
   wire dclk = ctrl_i[`PHW_C_DCLK];
   wire bcen = ctrl_i[`PHW_C_BCEN];
   wire fsen = ctrl_i[`PHW_C_FSEN];
   wire [13:0] inc = (`PHW_EDGE_KHZ << ctrl_i[1:0]) << dclk;
   wire [17:0] sum = acc_reg + {4'h0, inc};
   wire tick = mst & bcen & (sum >= `PHW_SYS_KHZ);
   wire bc = mst ? bq_reg : bclk_s_i;
   wire rise = bc & ~bp_reg;
   wire fall = ~bc & bp_reg;
   wire frise = fsc_s_i & ~fp_reg;
   wire ledge = ctrl_i[`PHW_C_TXE] ? fall : rise;
   wire launch = ledge & (~dclk | ~ph_reg);
   wire sample = (ctrl_i[`PHW_C_RXE] ? rise : fall) & (~dclk | ph_reg);
   wire [7:0] last = (8'h20 << ctrl_i[1:0]) - 8'h01;
   wire frm = launch & (mst ? (cnt_reg == last) : (fpend_reg | frise));
   wire [7:0] nb = frm ? 8'h00 : cnt_reg + 8'h01;
   wire drun_next = bcen & (frm ? (fsen & bclk_run_o) : data_run_o);
   wire [7:0] tshn = (nb[2:0] == 3'h0) ? tx_byte_i : {tsh_reg[6:0], 1'b0};
   assign slot_o = nb[7:3];
   assign swap_o = frm & data_run_o;

   // bit clock generation, framing and shifting
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_reg <= 18'h00000;
         bq_reg <= 1'b0;
         bp_reg <= 1'b0;
         fp_reg <= 1'b0;
         fpend_reg <= 1'b0;
         ph_reg <= 1'b0;
         en_reg <= 1'b0;
         cnt_reg <= 8'h00;
         tsh_reg <= 8'h00;
         rsh_reg <= 8'h00;
         wcnt_reg <= 3'h0;
         bclk_o <= 1'b0;
         bclk_oe_o <= 1'b0;
         fsc_o <= 1'b0;
         fsc_oe_o <= 1'b0;
         sdo_o <= 1'b0;
         sdo_oe_o <= 1'b0;
         rx_wr_o <= 1'b0;
         rx_slot_o <= 5'h00;
         rx_byte_o <= 8'h00;
         bcyc_o <= 9'h000;
         data_run_o <= 1'b0;
         bclk_run_o <= 1'b0;
      end else begin
         acc_reg <= ~(mst & bcen) ? 18'h00000 :
            tick ? sum - `PHW_SYS_KHZ : sum;
         bq_reg <= (mst & bcen) & (bq_reg ^ tick);
         bp_reg <= bc;
         fp_reg <= fsc_s_i;
         fpend_reg <= (fpend_reg | frise) & ~launch;
         if (ledge)
            ph_reg <= ~ph_reg & dclk;
         bclk_run_o <= bcen & (bclk_run_o | ~fsen | frm);
         data_run_o <= drun_next;
         bclk_o <= bq_reg & bclk_run_o;
         bclk_oe_o <= mst & bclk_run_o;
         fsc_oe_o <= mst & bcen;
         if (rise)
            bcyc_o <= frm ? 9'h000 : bcyc_o + 9'h001;
         if (launch) begin
            cnt_reg <= nb;
            tsh_reg <= tshn;
            sdo_o <= tshn[7];
            fsc_o <= fsen & (nb == 8'h00);
            en_reg <= drun_next &
               (ctrl_i[`PHW_C_PERM] | slot_en_i[nb[7:3]]);
            if (nb[2:0] == 3'h0 && ctrl_i[`PHW_C_WEN])
               wcnt_reg <= ctrl_i[`PHW_C_WHI:`PHW_C_WLO];
         end else if ((rise | fall) && wcnt_reg != 3'h0) begin
            wcnt_reg <= wcnt_reg - 3'h1;
         end
         sdo_oe_o <= en_reg & data_run_o & (wcnt_reg == 3'h0);
         if (sample)
            rsh_reg <= {rsh_reg[6:0], sdi_s_i};
         rx_wr_o <= sample & data_run_o & (cnt_reg[2:0] == 3'h7);
         rx_byte_o <= {rsh_reg[6:0], sdi_s_i};
         rx_slot_o <= cnt_reg[7:3];
      end
   end
endmodule // phw_port

// >>> logic/phw_top.v
// Purpose: three pcm highways with switching buffers
// Assumes: apb slave, 200 MHz clock, pins asynchronous, synchronised inside
// Notes: buffers are flip-flops, swap by bank select
`timescale 1ns/1ps
`include "phw_defines.vh"
// Operation
// - frame holds up to 32 one-byte slots
// - four rates, slots equal rate over 64k
// - frame sync always at 8 kHz
// - all highways share internal timing source; each highway here runs its own fractional tick counter
// - master drives clocks, slave follows them
// - every setting held per highway
// - third highway yields pins to uart
// - buffers swap on each frame pulse
// - swap disabled, both use current buffers
// - slots disabled after reset, bitmap enables
// - disabled slot leaves output floating
// - first highway has four peripheral syncs
// - edge selects and single or double clocking
// - turnaround count needs wait enable set
// - permanent enable drives continuous stream
// - together: clock after first, data second
// - clock settings act immediately, change disabled
// - sync off stops data next frame
// - word n holds slots 4n to 4n+3
// - peripheral sync start low, length high
// - bytes sent most significant bit first
module phw_top (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // bit clock pins
   input wire [2:0] bit_clock_pin_i,
   output wire [2:0] bit_clock_pin_o,
   output wire [2:0] bit_clock_pin_oe_o,
   // frame sync pins
   input wire [2:0] frame_sync_pin_i,
   output wire [2:0] frame_sync_pin_o,
   output wire [2:0] frame_sync_pin_oe_o,
   // serial data pins
   input wire [2:0] serial_in_pin_i,
   output wire [2:0] serial_out_pin_o,
   output wire [2:0] serial_out_pin_oe_o,
   // peripheral syncs and pin sharing
   output wire [3:0] periph_sync_out_o,
   output wire uart_owns_pins_o
);
   // buffer storage: index = bank*24 + highway*8 + word
   reg [31:0] txb_reg [0:47];
   reg [31:0] rxb_reg [0:47];
   reg [14:0] ctrl_reg [0:2];
   reg [31:0] tsen_reg [0:2];
   reg [15:0] pfs_reg [0:3];
   reg [2:0] tsel_reg;
   reg [2:0] rsel_reg;
   reg [31:0] prdata_reg;
   reg pready_reg;
   reg pslverr_reg;
   reg [3:0] pfs_out_reg;
   reg uart_reg;
   reg [31:0] rd;
   reg hit;
   integer i;

   // port side wires
   wire [8:0] syn;
   wire [14:0] slot_w;
   wire [2:0] swap_w;
   wire [2:0] rxwr_w;
   wire [14:0] rxslot_w;
   wire [23:0] rxbyte_w;
   wire [26:0] bcyc_w;
   wire [2:0] drun_w;
   wire [2:0] brun_w;

   // physical word index of one buffer word
   function [5:0] widx;
      input bank;
      input [1:0] h;
      input [2:0] n;
      begin
         widx = (bank ? 6'h18 : 6'h00) + {1'b0, h, n};
      end
   endfunction

   // byte lane pick
   function [7:0] lane;
      input [31:0] w;
      input [1:0] b;
      begin
         lane = w[{b, 3'h0} +: 8];
      end
   endfunction

   // byte strobe merge of a write
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
            if (strb[k])
               merge[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction

   // peripheral sync window test in bit clock cycles
   function pfs_hit;
      input [15:0] cfg;
      input [8:0] c;
      reg [9:0] stop;
      begin
         stop = {1'b0, cfg[8:0]} + {3'h0, cfg[15:9]};
         pfs_hit = (c >= cfg[8:0]) && ({1'b0, c} < stop);
      end
   endfunction

   // address decode
   wire [9:0] a = paddr_i[9:0];
   wire aok = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0);
   wire [1:0] h = a[7:6];
   wire rxv = a[5];
   // word n maps slots 4n up
   wire bufhit = ~a[9] & ~(&a[7:6]);
   wire bsel = rxv ? rsel_reg[h] : tsel_reg[h];
   // current view when swap is off
   wire bank = a[8] ? bsel : ~bsel;
   wire [5:0] bidx = widx(bank, h, a[4:2]);
   wire pfshit = (a[9:4] == `PHW_PG_PFS);
   wire tsenhit = (a[9:4] == `PHW_PG_TSEN) && (a[3:2] != 2'h3);
   wire ctlhit = (a[9:4] == `PHW_PG_CTRL) && (a[3:2] != 2'h0);
   wire [1:0] ch = a[3:2] - 2'h1;
   wire wr = psel_i & penable_i & pready_reg & pwrite_i & hit;
   // merged write words, cut to register width below
   wire [31:0] pfs_wr = merge({16'h0000, pfs_reg[a[3:2]]}, pwdata_i,
      pstrb_i);
   wire [31:0] ctl_wr = merge({17'h00000, ctrl_reg[ch]}, pwdata_i,
      pstrb_i);

   // read data and hit decode
   always @* begin
      rd = 32'h00000000;
      hit = 1'b0;
      if (aok) begin
         if (bufhit) begin
            hit = 1'b1;
            rd = rxv ? rxb_reg[bidx] : txb_reg[bidx];
         end else if (pfshit) begin
            hit = 1'b1;
            rd = {16'h0000, pfs_reg[a[3:2]]};
         end else if (tsenhit) begin
            hit = 1'b1;
            rd = tsen_reg[a[3:2]];
         end else if (ctlhit) begin
            hit = 1'b1;
            rd = {17'h00000, ctrl_reg[ch]};
            rd[`PHW_S_DATA] = drun_w[ch];
            rd[`PHW_S_BCLK] = brun_w[ch];
         end
      end
   end

   // apb answer one cycle into the access phase
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= psel_i & penable_i & ~pready_reg;
         pslverr_reg <= psel_i & penable_i & ~pready_reg & ~hit;
         if (psel_i & penable_i & ~pready_reg)
            prdata_reg <= (hit & ~pwrite_i) ? rd : 32'h00000000;
      end
   end

   // registers, buffers and bank swapping
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (i = 0; i < 48; i = i + 1) begin
            txb_reg[i] <= 32'h00000000;
            rxb_reg[i] <= 32'h00000000;
         end
         for (i = 0; i < 3; i = i + 1) begin
            ctrl_reg[i] <= `PHW_CTRL_RST;
            tsen_reg[i] <= `PHW_TSEN_RST;
         end
         for (i = 0; i < 4; i = i + 1)
            pfs_reg[i] <= `PHW_PFS_RST;
         tsel_reg <= 3'h0;
         rsel_reg <= 3'h0;
      end else begin
         if (wr & bufhit & ~rxv)
            txb_reg[bidx] <= merge(txb_reg[bidx], pwdata_i, pstrb_i);
         if (wr & bufhit & rxv)
            rxb_reg[bidx] <= merge(rxb_reg[bidx], pwdata_i, pstrb_i);
         if (wr & pfshit)
            pfs_reg[a[3:2]] <= pfs_wr[15:0];
         if (wr & tsenhit)
            tsen_reg[a[3:2]] <= merge(tsen_reg[a[3:2]], pwdata_i,
               pstrb_i);
         if (wr & ctlhit)
            ctrl_reg[ch] <= ctl_wr[14:0];
         for (i = 0; i < 3; i = i + 1) begin
            // received byte lands in current bank
            if (rxwr_w[i])
               rxb_reg[widx(rsel_reg[i], i[1:0],
                  rxslot_w[5*i+2 +: 3])][{rxslot_w[5*i +: 2], 3'h0} +: 8]
                  <= rxbyte_w[8*i +: 8];
            if (swap_w[i] & ~ctrl_reg[i][`PHW_C_BOFF]) begin
               tsel_reg[i] <= ~tsel_reg[i];
               rsel_reg[i] <= ~rsel_reg[i];
            end
         end
      end
   end

   // peripheral syncs on the first highway
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pfs_out_reg <= 4'h0;
         uart_reg <= 1'b0;
      end else begin
         for (i = 0; i < 4; i = i + 1)
            pfs_out_reg[i] <= drun_w[0] & pfs_hit(pfs_reg[i],
               bcyc_w[8:0]);
         uart_reg <= ctrl_reg[2][`PHW_C_UART];
      end
   end

   phw_sync #(
      .W(9)
   ) u_sync (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .d_i({serial_in_pin_i, frame_sync_pin_i, bit_clock_pin_i}),
      .q_o(syn)
   );

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : hw
         wire [14:0] pc;
         wire [5:0] ti;
         wire [7:0] tb;
         assign pc = (g == 2 && ctrl_reg[2][`PHW_C_UART]) ?
            (ctrl_reg[g] & `PHW_UART_MASK) : ctrl_reg[g];
         // new frame reads the bank about to become current
         assign ti = widx(tsel_reg[g] ^ (swap_w[g] &
            ~ctrl_reg[g][`PHW_C_BOFF]), g[1:0], slot_w[5*g+2 +: 3]);
         assign tb = lane(txb_reg[ti], slot_w[5*g +: 2]);
         phw_port u_port (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .ctrl_i(pc),
            .slot_en_i(tsen_reg[g]),
            .tx_byte_i(tb),
            .bclk_s_i(syn[g]),
            .fsc_s_i(syn[3+g]),
            .sdi_s_i(syn[6+g]),
            .bclk_o(bit_clock_pin_o[g]),
            .bclk_oe_o(bit_clock_pin_oe_o[g]),
            .fsc_o(frame_sync_pin_o[g]),
            .fsc_oe_o(frame_sync_pin_oe_o[g]),
            .sdo_o(serial_out_pin_o[g]),
            .sdo_oe_o(serial_out_pin_oe_o[g]),
            .slot_o(slot_w[5*g +: 5]),
            .swap_o(swap_w[g]),
            .rx_wr_o(rxwr_w[g]),
            .rx_slot_o(rxslot_w[5*g +: 5]),
            .rx_byte_o(rxbyte_w[8*g +: 8]),
            .bcyc_o(bcyc_w[9*g +: 9]),
            .data_run_o(drun_w[g]),
            .bclk_run_o(brun_w[g])
         );
      end
   endgenerate

   // registered outputs
   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign periph_sync_out_o = pfs_out_reg;
   assign uart_owns_pins_o = uart_reg;
endmodule // phw_top

// >>> bench/phw_top_properties.sv
// Purpose: port level checks for the pcm highway block
// Assumes: apb with one wait state, control writes use all strobes
// Notes: copies of control words follow completed writes
`timescale 1ns/1ps
module phw_top_properties (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // apb
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   // pin drive
   input wire [2:0] bit_clock_pin_oe_o,
   input wire [2:0] frame_sync_pin_oe_o,
   input wire [2:0] serial_out_pin_oe_o,
   input wire [3:0] periph_sync_out_o,
   input wire uart_owns_pins_o
);
   reg [14:0] c0_reg;
   reg [14:0] c1_reg;
   wire wr_done;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // completed full word write
   assign wr_done = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o
      & (pstrb_i == 4'hF);
   // control copies of highways 1 and 2
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         c0_reg <= 15'h0000;
         c1_reg <= 15'h0000;
      end else if (wr_done && paddr_i == 12'h204) begin
         c0_reg <= pwdata_i[14:0];
      end else if (wr_done && paddr_i == 12'h208) begin
         c1_reg <= pwdata_i[14:0];
      end
   end
   // bus answer timing
   AST_READY_LAT: assert property (
      $rose(penable_i) && psel_i |=> pready_o)
      else $error("ready not in second access cycle");
   AST_READY_PULSE: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   AST_READY_IDLE: assert property (
      !(psel_i && penable_i) |-> !pready_o)
      else $error("ready outside access phase");
   AST_ERR_ZERO: assert property (
      pslverr_o |-> pready_o && prdata_o == 32'h0)
      else $error("error answer malformed");
   // pin ownership
   AST_UART_PARK: assert property (
      uart_owns_pins_o && $past(uart_owns_pins_o) |->
      {bit_clock_pin_oe_o[2], frame_sync_pin_oe_o[2],
       serial_out_pin_oe_o[2]} == 3'h0)
      else $error("third highway drives uart pins");
   AST_FSC_OE: assert property (
      $past(c0_reg, 2) == c0_reg && $past(c0_reg) == c0_reg |->
      frame_sync_pin_oe_o[0] == (c0_reg[9] & c0_reg[12]))
      else $error("frame sync drive wrong");
   AST_SLAVE_QUIET: assert property (
      $past(c1_reg, 2) == c1_reg && $past(c1_reg) == c1_reg && !c1_reg[9]
      |-> !bit_clock_pin_oe_o[1] && !frame_sync_pin_oe_o[1])
      else $error("slave drives clock pins");
   AST_BCLK_OFF: assert property (
      $past(c0_reg, 2) == c0_reg && $past(c0_reg) == c0_reg && !c0_reg[12]
      |-> !bit_clock_pin_oe_o[0] && periph_sync_out_o == 4'h0)
      else $error("clock or syncs run while disabled");
   AST_SDO_NOCLK: assert property (
      $past(c1_reg, 2) == c1_reg && $past(c1_reg) == c1_reg && !c1_reg[12]
      |-> !serial_out_pin_oe_o[1])
      else $error("data driven without bit clock");
   // main scenarios
   COV_ERR: cover property (pslverr_o);
   COV_UART: cover property (uart_owns_pins_o);
   COV_RUN: cover property (frame_sync_pin_oe_o[0] && bit_clock_pin_oe_o[0]);
endmodule // phw_top_properties

// >>> bench/phw_codec_model.sv
// Purpose: codec on highway 2, clock master towards the device
// Assumes: top rate, 256 bits a frame, 64 ns bit clock
// Notes: sdo sampled at the rising edge after its launch
`timescale 1ns/1ps
module phw_codec_model (
   // data from the device
   input wire sdo_i,
   input wire sdo_oe_i,
   // clocks and data towards the device
   output reg bclk_o,
   output reg fsc_o,
   output reg sdi_o
);
   reg [7:0] got [0:31];
   reg [31:0] seen;
   reg [7:0] bit_n;
   reg [7:0] prv;
   reg [7:0] sh;
   reg [7:0] tx;
   initial begin
      bclk_o = 1'b0;
      fsc_o = 1'b0;
      sdi_o = 1'b0;
      bit_n = 8'h00;
      seen = 32'h0;
      sh = 8'h00;
      forever begin
         #32;
         bclk_o = ~bclk_o;
         if (bclk_o) begin
            // capture previous bit and its drive
            prv = bit_n - 8'h01;
            sh = {sh[6:0], sdo_i};
            if (sdo_oe_i)
               seen[prv[7:3]] = 1'b1;
            if (prv[2:0] == 3'h7)
               got[prv[7:3]] = sh;
            // sync on bit 0, msb first
            fsc_o = (bit_n == 8'h00);
            tx = 8'h90 + {3'h0, bit_n[7:3]};
            sdi_o = tx[7 - bit_n[2:0]];
            bit_n = bit_n + 8'h01;
         end
      end
   end
endmodule // phw_codec_model

// >>> bench/phw_top_tb.sv
// Purpose: register and link tests of the pcm highway block
// Assumes: highway 1 master, highway 2 slave to the codec model
// Notes: frame of highway 1 is 25000 clocks
`timescale 1ns/1ps
module phw_top_tb;
   reg clock_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg psel_i = 1'b0;
   reg penable_i = 1'b0;
   reg pwrite_i = 1'b0;
   reg [11:0] paddr_i = 12'h000;
   reg [31:0] pwdata_i = 32'h0;
   reg [3:0] pstrb_i = 4'h0;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, uart, m_bclk, m_fsc, m_sdi;
   wire [2:0] bc_o, bc_oe, fs_o, fs_oe, sd_o, sd_oe, bc_i, fs_i, sd_i;
   wire [3:0] pfs;
   integer errors = 0;
   integer n_tests = 0;
   integer per = 0;
   real t_last = 0.0;
   reg [31:0] rd;
   reg er;
   always #2.5 clock_i = ~clock_i;
   // pin levels from all drivers, pull-ups on idle data
   assign bc_i = {1'b0, bc_oe[1] ? bc_o[1] : m_bclk, bc_oe[0] & bc_o[0]};
   assign fs_i = {1'b0, fs_oe[1] ? fs_o[1] : m_fsc, fs_oe[0] & fs_o[0]};
   assign sd_i = {1'b1, m_sdi, 1'b1};
   phw_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .bit_clock_pin_i(bc_i),
      .bit_clock_pin_o(bc_o), .bit_clock_pin_oe_o(bc_oe),
      .frame_sync_pin_i(fs_i), .frame_sync_pin_o(fs_o),
      .frame_sync_pin_oe_o(fs_oe), .serial_in_pin_i(sd_i),
      .serial_out_pin_o(sd_o), .serial_out_pin_oe_o(sd_oe),
      .periph_sync_out_o(pfs), .uart_owns_pins_o(uart));
   phw_codec_model u_codec (.sdo_i(sd_oe[1] ? sd_o[1] : 1'b1),
      .sdo_oe_i(sd_oe[1]), .bclk_o(m_bclk), .fsc_o(m_fsc), .sdi_o(m_sdi));
   task stop_test;
      begin
         $display("COUNT checks %0d mismatches %0d", n_tests, errors);
         if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task chk32(input [31:0] g, input [31:0] e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   task chk1(input g, input e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %0t: flag %b want %b", $time, g, e);
         end
      end
   endtask
   task hang(input string m);
      begin
         errors = errors + 1;
         $display("CHECK FAILED %0t: timeout %0s", $time, m);
         stop_test;
      end
   endtask
   // one apb transfer, held until ready
   task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
      integer n;
      begin
         @(posedge clock_i);
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= d;
         pstrb_i <= s;
         @(posedge clock_i);
         penable_i <= 1'b1;
         n = 0;
         // ready is looked at mid-cycle, the request stands to the next edge
         @(negedge clock_i);
         while (pready_o !== 1'b1 && n < 16) begin
            @(negedge clock_i);
            n = n + 1;
         end
         rd = prdata_o;
         er = pslverr_o;
         @(posedge clock_i);
         psel_i <= 1'b0;
         penable_i <= 1'b0;
         if (n == 16)
            hang("apb");
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   task rchk(input [11:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0, 4'h0);
         chk32(rd, e);
         chk1(er, 1'b0);
      end
   endtask
   // next rising frame sync of highway 1, period in clocks
   task wait_fs;
      integer n;
      reg p;
      begin
         n = 0;
         p = 1'b1;
         @(posedge clock_i);
         while (!(fs_o[0] === 1'b1 && p === 1'b0) && n < 30000) begin
            p = fs_o[0];
            @(posedge clock_i);
            n = n + 1;
         end
         if (n == 30000)
            hang("frame sync");
         per = $rtoi(($realtime - t_last) / 5.0 + 0.5);
         t_last = $realtime;
      end
   endtask
   task done(input string nm);
      $display("TEST %0s ended, mismatches %0d", nm, errors);
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rchk(12'h204, 32'h0);
      rchk(12'h20C, 32'h0);
      rchk(12'h1E0, 32'h0);
      rchk(12'h100, 32'h0);
      apb(1'b0, 12'h3F0, 32'h0, 4'h0);
      chk1(er, 1'b1);
      done("reset");
      apb(1'b1, 12'h008, 32'h11223344, 4'h5);
      rchk(12'h008, 32'h00220044);
      wr(12'h1D0, 32'h00001234);
      rchk(12'h1D0, 32'h00001234);
      wr(12'h20C, 32'h00004000);
      rchk(12'h20C, 32'h00004000);
      chk1(uart, 1'b1);
      wr(12'h20C, 32'h0);
      done("regs");
      wr(12'h040, 32'h3C0000A5);
      wr(12'h140, 32'h3C0000A5);
      wr(12'h1E4, 32'h00000009);
      wr(12'h208, 32'h00003003);
      wr(12'h204, 32'h00003203);
      repeat (4) @(posedge clock_i);
      chk1(fs_oe[0], 1'b1);
      chk1(bc_oe[0], 1'b0);
      wait_fs;
      repeat (120) @(posedge clock_i);
      chk1(bc_oe[0], 1'b1);
      chk32({24'h0, u_codec.got[0]}, 32'hA5);
      chk32({24'h0, u_codec.got[3]}, 32'h3C);
      chk32(u_codec.seen, 32'h00000009);
      rchk(12'h060, 32'h93929190);
      rchk(12'h064, 32'h97969594);
      done("slave");
      wr(12'h208, 32'h00003803);
      wr(12'h140, 32'h3C00005A);
      wait_fs;
      chk32(per, 32'd25000);
      chk32({24'h0, u_codec.got[0]}, 32'h5A);
      rchk(12'h160, 32'h93929190);
      rchk(12'h204, 32'h00033203);
      repeat (5450) @(posedge clock_i);
      chk1(pfs[0], 1'b1);
      chk1(pfs[1], 1'b0);
      done("swap");
      wr(12'h204, 32'h00001203);
      // no pin pulse with sync off: wait one full internal frame
      repeat (25200) @(posedge clock_i);
      chk1(fs_o[0], 1'b0);
      rchk(12'h204, 32'h00021203);
      wr(12'h204, 32'h00000203);
      repeat (4) @(posedge clock_i);
      chk1(bc_oe[0], 1'b0);
      rchk(12'h204, 32'h00000203);
      done("stop");
      stop_test;
   end
endmodule // phw_top_tb
bind phw_top phw_top_properties u_props (.clock_i(clock_i),
   .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .bit_clock_pin_oe_o(bit_clock_pin_oe_o),
   .frame_sync_pin_oe_o(frame_sync_pin_oe_o),
   .serial_out_pin_oe_o(serial_out_pin_oe_o),
   .periph_sync_out_o(periph_sync_out_o),
   .uart_owns_pins_o(uart_owns_pins_o));
